// ---- acs_ctrl.sv ----
/*
 * Conversion start and synchronisation controller with AHB-Lite
 * register port, start pin, completion output and clock output.
 * Assumes start pin and master clock pin are synchronous to hclk.
 */
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module acs_ctrl
   import acs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic start_pin,
   input wire logic ext_master_clock_pin,
   output logic conv_done_out,
   output logic clock_out_gpio
);

   // ************************************************************
   // State and decoded events
   // ************************************************************
   acs_state_t s_q; // Registered state
   acs_state_t s_d; // Next state
   logic addr_phase; // Valid AHB address phase
   logic cmd_wr; // Command register written this cycle
   acs_cmd_t cmd; // Written command code
   logic is_mode_cmd; // Command selects a reading mode
   logic sync_rise; // Start pin rising edge
   logic ext_rise; // Master clock rising edge
   logic sys_tick; // One sys clock period elapsed
   logic start_evt; // Reading start event
   logic last_read; // Reading completes this tick

   // Bus answers are fixed: zero wait states, always OKAY
   logic hreadyout_q;
   logic hresp_q;

   // ************************************************************
   // Event decode
   // ************************************************************
   always_comb begin
      addr_phase = hsel && htrans[1] && hready;
      cmd_wr = s_q.wr_pend && (s_q.addr == ACS_COMMAND_REG);
      cmd = cmd_wr ? acs_cmd_t'(hwdata[2:0]) : ACS_CMD_NONE;
      is_mode_cmd = (cmd != ACS_CMD_NONE) && (cmd != ACS_CMD_END) &&
         (cmd != ACS_CMD_ABORT);
      // Low sample then high sample on the start pin
      sync_rise = s_q.sync_cur && !s_q.sync_prev;
      ext_rise = s_q.ext_cur && !s_q.ext_prev;
      // Sys tick from the selected master clock source
      if (s_q.clk_src == ACS_CLK_SRC_EXT) begin
         sys_tick = ext_rise && (s_q.ext_cnt == ACS_EXT_LAST);
      end else begin
         sys_tick = (s_q.int_cnt == ACS_INT_LAST);
      end
      // Start source follows the stored select bit only, so a
      // config write affects edges seen after it completes.
      if (s_q.trig_sel) begin
         start_evt = sync_rise;
      end else begin
         start_evt = is_mode_cmd;
      end
      last_read = (s_q.fsm == ACS_CONV) && sys_tick && (s_q.cnt == 16'h0001);
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_d = s_q;
      s_d.sync_prev = s_q.sync_cur;
      s_d.sync_cur = start_pin;
      s_d.ext_prev = s_q.ext_cur;
      s_d.ext_cur = ext_master_clock_pin;

      // Master and internal dividers
      if (ext_rise) begin
         s_d.ext_cnt = s_q.ext_cnt + 2'h1;
      end
      if (s_q.int_cnt == ACS_INT_LAST) begin
         s_d.int_cnt = 4'h0;
      end else begin
         s_d.int_cnt = s_q.int_cnt + 4'h1;
      end

      // System clock copy on the gpio, low while disabled
      if (!s_q.clkout_en) begin
         s_d.clkout = 1'b0;
      end else if (s_q.clk_src == ACS_CLK_SRC_EXT) begin
         s_d.clkout = s_q.ext_cnt[1];
      end else begin
         s_d.clkout = (s_q.int_cnt < ACS_INT_HALF);
      end

      // Done stays high for one sys period after completion
      if (sys_tick && s_q.done) begin
         s_d.done = 1'b0;
      end

      // Reading sequencer
      if (s_q.fsm == ACS_CONV && sys_tick) begin
         if (last_read) begin
            s_d.done = 1'b1;
            s_d.readings = s_q.readings + 16'h0001;
            s_d.cnt = s_q.conv_len;
            if (s_q.stop_pend || s_q.mode == ACS_CMD_SS ||
                s_q.mode == ACS_MULTI_CH_SINGLE_CMD) begin
               s_d.fsm = ACS_IDLE;
               s_d.stop_pend = 1'b0;
            end else if (s_q.mode == ACS_MULTI_CH_MULTI_CMD &&
                         s_q.chan + 4'h1 >= s_q.chan_count) begin
               // Scan of all channels done once
               s_d.fsm = ACS_IDLE;
               s_d.chan = 4'h0;
            end else if (s_q.mode == ACS_SINGLE_CH_CONTINUOUS_CMD) begin
               s_d.chan = s_q.chan;
            end else if (s_q.chan + 4'h1 >= s_q.chan_count) begin
               s_d.chan = 4'h0;
            end else begin
               s_d.chan = s_q.chan + 4'h1;
            end
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end

      // Commands: mode always latched; end acts here, abort after the start below
      if (is_mode_cmd) begin
         s_d.mode = cmd;
      end
      if (cmd == ACS_CMD_END && s_d.fsm == ACS_CONV) begin
         s_d.stop_pend = 1'b1;
      end

      // Start wins over completion; a running reading is dropped
      if (start_evt) begin
         s_d.fsm = ACS_CONV;
         s_d.cnt = s_q.conv_len;
         s_d.chan = 4'h0;
         s_d.stop_pend = 1'b0;
      end
      if (cmd == ACS_CMD_ABORT) begin
         s_d.fsm = ACS_IDLE;
         s_d.stop_pend = 1'b0;
         s_d.chan = 4'h0;
      end

      // Register writes in the data phase
      s_d.wr_pend = addr_phase && hwrite;
      if (addr_phase) begin
         s_d.addr = haddr[7:0];
      end
      if (s_q.wr_pend) begin
         unique case (s_q.addr)
            ACS_SYSTEM_CONFIG_REG: begin
               s_d.trig_sel = hwdata[ACS_TRIG_SEL_BIT];
               s_d.clkout_en = hwdata[ACS_CLKOUT_EN_BIT];
               s_d.clk_src = hwdata[ACS_CLK_SRC_LSB +: 2];
            end
            ACS_CONV_LEN_REG: begin
               // Zero would wrap and run 65536 ticks; hold at least one tick
               s_d.conv_len = (hwdata[15:0] == 16'h0000) ?
                  16'h0001 : hwdata[15:0];
            end
            ACS_CHAN_COUNT_REG: begin
               s_d.chan_count = (hwdata[3:0] == 4'h0) ?
                  4'h1 : hwdata[3:0];
            end
            default: begin
               // Command, read-only or unmapped: nothing stored here
            end
         endcase
      end

      // Read data prepared in the address phase, unmapped reads zero
      s_d.rdata = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            ACS_SYSTEM_CONFIG_REG: begin
               s_d.rdata[ACS_TRIG_SEL_BIT] = s_q.trig_sel;
               s_d.rdata[ACS_CLKOUT_EN_BIT] = s_q.clkout_en;
               s_d.rdata[ACS_CLK_SRC_LSB +: 2] = s_q.clk_src;
            end
            ACS_STATUS_REG: begin
               s_d.rdata[ACS_STAT_BUSY_BIT] = (s_q.fsm == ACS_CONV);
               s_d.rdata[ACS_STAT_MODE_LSB +: 3] = s_q.mode;
               s_d.rdata[ACS_STAT_DONE_BIT] = s_q.done;
               s_d.rdata[ACS_STAT_STOP_BIT] = s_q.stop_pend;
               s_d.rdata[ACS_STAT_CHAN_LSB +: 4] = s_q.chan;
            end
            ACS_CONV_LEN_REG: begin
               s_d.rdata[15:0] = s_q.conv_len;
            end
            ACS_CHAN_COUNT_REG: begin
               s_d.rdata[3:0] = s_q.chan_count;
            end
            ACS_READINGS_REG: begin
               s_d.rdata[15:0] = s_q.readings;
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.conv_len <= ACS_CONV_LEN_RST;
         s_q.chan_count <= ACS_CHAN_COUNT_RST;
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         s_q <= s_d;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = s_q.rdata;
   assign conv_done_out = s_q.done;
   assign clock_out_gpio = s_q.clkout;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_pin_start;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.trig_sel && sync_rise && cmd != ACS_CMD_ABORT) |=>
         (s_q.fsm == ACS_CONV && s_q.cnt == s_q.conv_len);
   endproperty
   a_pin_start: assert property (p_pin_start)
      else $error("pin edge did not start a reading");

   property p_restart;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.fsm == ACS_CONV && s_q.trig_sel && start_pin &&
       !s_q.sync_cur && cmd != ACS_CMD_ABORT) |=> ##1
         (s_q.fsm == ACS_CONV && s_q.chan == 4'h0);
   endproperty
   a_restart: assert property (p_restart)
      else $error("running reading not restarted by pin edge");

   property p_mode_only;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.trig_sel && is_mode_cmd && !sync_rise &&
       s_q.fsm == ACS_IDLE) |=> (s_q.fsm == ACS_IDLE &&
         s_q.mode == $past(cmd));
   endproperty
   a_mode_only: assert property (p_mode_only)
      else $error("command started reading under pin trigger");

   property p_pin_ignored;
      @(posedge hclk) disable iff (!hresetn)
      (!s_q.trig_sel && sync_rise && !is_mode_cmd &&
       s_q.fsm == ACS_IDLE) |=> (s_q.fsm == ACS_IDLE);
   endproperty
   a_pin_ignored: assert property (p_pin_ignored)
      else $error("pin edge acted under command trigger");

   property p_cmd_start;
      @(posedge hclk) disable iff (!hresetn)
      (!s_q.trig_sel && is_mode_cmd) |=>
         (s_q.fsm == ACS_CONV && s_q.cnt == s_q.conv_len);
   endproperty
   a_cmd_start: assert property (p_cmd_start)
      else $error("command did not start a reading");

   property p_done_count;
      @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.done) |->
         (s_q.readings == $past(s_q.readings) + 16'h0001);
   endproperty
   a_done_count: assert property (p_done_count)
      else $error("done rose without a completed reading");

   property p_clkout_off;
      @(posedge hclk) disable iff (!hresetn)
      (!s_q.clkout_en) ##1 (!s_q.clkout_en) |-> !clock_out_gpio;
   endproperty
   a_clkout_off: assert property (p_clkout_off)
      else $error("clock output driven while disabled");

   property p_end_finish;
      @(posedge hclk) disable iff (!hresetn)
      (last_read && s_q.stop_pend && !start_evt && cmd == ACS_CMD_NONE)
         |=> (s_q.fsm == ACS_IDLE && s_q.done);
   endproperty
   a_end_finish: assert property (p_end_finish)
      else $error("end command did not finish then idle");

   property p_abort;
      @(posedge hclk) disable iff (!hresetn)
      (cmd == ACS_CMD_ABORT) |=> (s_q.fsm == ACS_IDLE && !s_q.stop_pend);
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort did not idle at once");

endmodule : acs_ctrl

// ---- acs_pkg.sv ----
/*
 * Package for the conversion start and synchronisation controller:
 * register map, field positions, command codes, modes and timing.
 * Assumes a single 40 MHz bus clock and an AHB-Lite register port.
 */
package acs_pkg;

   // ************************************************************
   // Register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam logic [7:0] ACS_SYSTEM_CONFIG_REG = 8'h00; // Config bits
   localparam logic [7:0] ACS_COMMAND_REG = 8'h04; // Command codes
   localparam logic [7:0] ACS_STATUS_REG = 8'h08; // Block state
   localparam logic [7:0] ACS_CONV_LEN_REG = 8'h0C; // Sys clocks/reading
   localparam logic [7:0] ACS_CHAN_COUNT_REG = 8'h10; // Scan length
   localparam logic [7:0] ACS_READINGS_REG = 8'h14; // Completed readings

   // Config field positions
   localparam int ACS_TRIG_SEL_BIT = 0; // 1: start pin triggers
   localparam int ACS_CLKOUT_EN_BIT = 1; // 1: sys clock on gpio
   localparam int ACS_CLK_SRC_LSB = 2; // clock_source_field[1:0]

   // Clock source field values
   localparam logic [1:0] ACS_CLK_SRC_INT = 2'h0;
   localparam logic [1:0] ACS_CLK_SRC_EXT = 2'h1;

   // Status field positions
   localparam int ACS_STAT_BUSY_BIT = 0; // Reading in progress
   localparam int ACS_STAT_MODE_LSB = 1; // Reading mode, three bits
   localparam int ACS_STAT_DONE_BIT = 4; // Copy of conv_done_out
   localparam int ACS_STAT_STOP_BIT = 5; // End command pending
   localparam int ACS_STAT_CHAN_LSB = 8; // Active channel, four bits

   // Reset values
   localparam logic [15:0] ACS_CONV_LEN_RST = 16'h0010;
   localparam logic [3:0] ACS_CHAN_COUNT_RST = 4'h4;

   // ************************************************************
   // Commands and reading modes
   // ************************************************************
   typedef enum logic [2:0] {
      ACS_CMD_NONE = 3'b000,
      ACS_CMD_SS = 3'b001, // One channel, one reading
      ACS_SINGLE_CH_CONTINUOUS_CMD = 3'b010, // One channel, repeating
      ACS_MULTI_CH_SINGLE_CMD = 3'b011, // One reading, then idle
      ACS_MULTI_CH_MULTI_CMD = 3'b100, // Each channel once
      ACS_MULTI_CH_CONTINUOUS_CMD = 3'b101, // All channels, repeating
      ACS_CMD_END = 3'b110, // Stop after current reading
      ACS_CMD_ABORT = 3'b111 // Stop at once
   } acs_cmd_t;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_CONV = 2'b01
   } acs_fsm_t;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int ACS_MASTER_DIV = 4; // Master clock / 4 = sys clock
   localparam int ACS_HCLK_HZ = 40_000_000;
   localparam int ACS_SYS_HZ = 4_608_000;
   // Internal sys tick period in bus clocks, rounded down
   localparam int ACS_INT_DIV = ACS_HCLK_HZ / ACS_SYS_HZ;
   localparam logic [3:0] ACS_INT_LAST = 4'(ACS_INT_DIV - 1);
   localparam logic [3:0] ACS_INT_HALF = 4'(ACS_INT_DIV / 2);
   localparam logic [1:0] ACS_EXT_LAST = 2'(ACS_MASTER_DIV - 1);

   // ************************************************************
   // State of the controller except the bus answer flops
   // ************************************************************
   typedef struct packed {
      acs_fsm_t fsm; // Conversion state
      acs_cmd_t mode; // Selected reading mode
      logic stop_pend; // End command seen
      logic [15:0] cnt; // Sys ticks left in reading
      logic [3:0] chan; // Active channel pointer
      logic trig_sel; // Start trigger select
      logic clkout_en; // System clock output enable
      logic [1:0] clk_src; // clock_source_field
      logic [15:0] conv_len; // Reading length
      logic [3:0] chan_count; // Channels in a scan
      logic [15:0] readings; // Completed readings
      logic done; // conv_done_out
      logic sync_prev; // Previous start pin sample
      logic sync_cur; // Current start pin sample
      logic ext_prev; // Previous master clock sample
      logic ext_cur; // Current master clock sample
      logic [1:0] ext_cnt; // Master clock divider
      logic [3:0] int_cnt; // Internal divider
      logic clkout; // clock_out_gpio
      logic wr_pend; // AHB write data phase pending
      logic [7:0] addr; // Latched AHB address
      logic [31:0] rdata; // AHB read data
   } acs_state_t;

endpackage : acs_pkg

// ---- acs_host_model.sv ----
/*
 * Host-side model for the conversion controller: start pulses on the
 * shared start line and an optional 18.432 MHz master clock.
 * Assumes the bench calls send_start and drives ext_run.
 */
`timescale 1ns/1ps

module acs_host_model #(
   parameter int PULSE_CYC = 18 // Two sys clocks (434 ns) with margin
)(
   input wire logic hclk,
   input wire logic ext_run,
   output logic start_pin,
   output logic ext_master_clock_pin
);

   // ************************************************************
   // Start line
   // ************************************************************
   // One pulse, launched just after an edge and held long enough
   task automatic send_start();
      @(posedge hclk);
      start_pin <= 1'b1;
      repeat (PULSE_CYC) @(posedge hclk);
      start_pin <= 1'b0;
   endtask : send_start

   // ************************************************************
   // Master clock
   // ************************************************************
   // Offset keeps every edge clear of an hclk edge; low when stopped
   initial begin
      start_pin = 1'b0;
      ext_master_clock_pin = 1'b0;
      #0.3;
      forever begin
         #27.125;
         ext_master_clock_pin = ext_run ? ~ext_master_clock_pin : 1'b0;
      end
   end

endmodule : acs_host_model

// ---- test_acs_ctrl.sv ----
/*
 * Self-checking bench for the conversion controller: register table,
 * command and pin starts in all modes, restart, abort, clocks, reset.
 * Assumes acs_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps

`define CHK(got, exp) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
   end \
end

module test_acs_ctrl;
   import acs_pkg::*;

   typedef struct {
      logic wr;
      logic [7:0] addr;
      logic [31:0] wd;
      logic [31:0] exp;
   } acs_row_t;

   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic ext_run = 1'b0; // Host master clock running
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, conv_done_out, clock_out_gpio;
   logic start_pin, ext_master_clock_pin;
   logic [31:0] hrdata, rd;
   logic done_q = 1'b0;
   int err_count = 0;
   int compares = 0;
   int rises = 0; // Completion pulses seen
   int n, tog, r0, m;

   // Write a value, read it back and expect the stored value
   acs_row_t rows [10] = '{
      '{1'b1, ACS_CONV_LEN_REG, 32'h0, 32'h1},
      '{1'b1, ACS_CONV_LEN_REG, 32'h3, 32'h3},
      '{1'b1, ACS_CHAN_COUNT_REG, 32'h0, 32'h1},
      '{1'b1, ACS_CHAN_COUNT_REG, 32'h2, 32'h2},
      '{1'b1, ACS_READINGS_REG, 32'hFFFF, 32'h0}, // Read-only
      '{1'b1, 8'h20, 32'h5, 32'h0}, // Unmapped
      '{1'b1, ACS_STATUS_REG, 32'hFF, 32'h0}, // Read-only, idle
      '{1'b1, ACS_SYSTEM_CONFIG_REG, 32'h2, 32'h2},
      '{1'b1, ACS_SYSTEM_CONFIG_REG, 32'h5, 32'h5},
      '{1'b1, ACS_SYSTEM_CONFIG_REG, 32'h0, 32'h0}};
   logic [7:0] ra [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] re [5] = '{32'h0, 32'h0, 32'h10, 32'h4, 32'h0};

   always #12.5 hclk = ~hclk;

   acs_ctrl acs_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .start_pin, .ext_master_clock_pin, .conv_done_out,
      .clock_out_gpio);

   acs_host_model acs_host_model_inst (.hclk, .ext_run, .start_pin,
      .ext_master_clock_pin);

   // Count completion pulses on their rising sample
   always @(posedge hclk) begin
      done_q <= conv_done_out;
      if (conv_done_out === 1'b1 && done_q === 1'b0) rises++;
   end

   // ************************************************************
   // Bus and wait helpers
   // ************************************************************
   // One single AHB-Lite transfer; read data land in rd
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {24'h00_0000, a};
      do begin @(posedge hclk); k++; end
      while (hreadyout !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge hclk); k++; end
      while (hreadyout !== 1'b1 && k < 50);
      rd = hrdata;
      if (k >= 50) err_count++;
   endtask : bus

   // Cycles until the completion output goes (again) high
   task automatic wait_rise(input int lim, output int c);
      c = 0;
      while (conv_done_out === 1'b1 && c < lim) begin
         @(posedge hclk);
         c++;
      end
      while (conv_done_out !== 1'b1 && c < lim) begin
         @(posedge hclk);
         c++;
      end
   endtask : wait_rise

   // Start pulse from the host, timed to the completion
   task automatic pin_start(input int lim, output int c);
      fork
         acs_host_model_inst.send_start();
      join_none
      wait_rise(lim, c);
   endtask : pin_start

   task automatic count_tog(input int lim, output int t);
      logic c;
      t = 0;
      repeat (lim) begin
         c = clock_out_gpio;
         @(posedge hclk);
         if (clock_out_gpio !== c) t++;
      end
   endtask : count_tog

   task automatic finish_test();
      if (err_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      foreach (rows[i]) begin
         if (rows[i].wr) bus(1'b1, rows[i].addr, rows[i].wd);
         bus(1'b0, rows[i].addr, 32'h0);
         `CHK(rd, rows[i].exp)
      end
      // Command trigger: each mode starts on its own command
      for (m = 1; m <= 5; m++) begin
         bus(1'b1, ACS_COMMAND_REG, 32'(m));
         bus(1'b0, ACS_STATUS_REG, 32'h0);
         `CHK(rd[3:0], {3'(m), 1'b1})
         wait_rise(200, n);
         `CHK((n >= 6 && n <= 32), 1'b1)
         bus(1'b1, ACS_COMMAND_REG, 32'h6);
         repeat (80) @(posedge hclk);
         bus(1'b0, ACS_STATUS_REG, 32'h0);
         `CHK(rd[0], 1'b0)
         bus(1'b0, ACS_READINGS_REG, 32'h0);
         `CHK(rd[15:0], 16'(rises))
      end
      // Abort right after a start gives no completion at all
      r0 = rises;
      bus(1'b1, ACS_CONV_LEN_REG, 32'h8);
      bus(1'b1, ACS_COMMAND_REG, 32'h2);
      bus(1'b1, ACS_COMMAND_REG, 32'h7);
      bus(1'b0, ACS_STATUS_REG, 32'h0);
      `CHK(rd[0], 1'b0)
      repeat (100) @(posedge hclk);
      `CHK(rises, r0)
      // Pin trigger: commands only pick the mode, the pin starts
      bus(1'b1, ACS_CONV_LEN_REG, 32'h3);
      bus(1'b1, ACS_SYSTEM_CONFIG_REG, 32'h1);
      for (m = 1; m <= 5; m++) begin
         bus(1'b1, ACS_COMMAND_REG, 32'(m));
         bus(1'b0, ACS_STATUS_REG, 32'h0);
         `CHK(rd[3:0], {3'(m), 1'b0})
         pin_start(200, n);
         `CHK((n >= 16 && n <= 36), 1'b1)
         bus(1'b1, ACS_COMMAND_REG, 32'h7);
      end
      // Second edge mid-reading restarts it; one completion only
      bus(1'b1, ACS_CONV_LEN_REG, 32'h8);
      bus(1'b1, ACS_COMMAND_REG, 32'h1);
      r0 = rises;
      fork
         acs_host_model_inst.send_start();
      join_none
      repeat (30) @(posedge hclk);
      pin_start(200, n);
      `CHK((n >= 56 && n <= 76), 1'b1)
      // Back to command trigger: later pulses are ignored
      bus(1'b1, ACS_SYSTEM_CONFIG_REG, 32'h0);
      `CHK(rises, r0 + 1)
      pin_start(100, n);
      `CHK(rises, r0 + 1)
      // Clock output from internal, then external source
      bus(1'b1, ACS_SYSTEM_CONFIG_REG, 32'h2);
      count_tog(64, tog);
      `CHK((tog >= 12), 1'b1)
      bus(1'b1, ACS_SYSTEM_CONFIG_REG, 32'h6);
      // Let the last internal-source level leave the output first
      repeat (2) @(posedge hclk);
      count_tog(64, tog);
      `CHK(tog, 0)
      ext_run <= 1'b1;
      count_tog(100, tog);
      `CHK((tog >= 20 && tog <= 26), 1'b1)
      bus(1'b1, ACS_COMMAND_REG, 32'h2);
      wait_rise(200, n);
      wait_rise(200, n);
      `CHK((n >= 67 && n <= 72), 1'b1)
      bus(1'b1, ACS_COMMAND_REG, 32'h7);
      bus(1'b1, ACS_SYSTEM_CONFIG_REG, 32'h0);
      ext_run <= 1'b0;
      // Reset in mid-reading clears outputs and returns registers to reset values
      bus(1'b1, ACS_COMMAND_REG, 32'h2);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      `CHK({hreadyout, hresp, conv_done_out, clock_out_gpio}, 4'h0)
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      for (m = 0; m < 5; m++) begin
         bus(1'b0, ra[m], 32'h0);
         `CHK(rd, re[m])
      end
      finish_test();
   end

   // Hang guard, well beyond the fewer than two thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      finish_test();
   end

endmodule : test_acs_ctrl
